// ---- include/pwrseq_defines.svh ----
// timing, command and layout constants of the host interface power-up sequencer
`ifndef PWRSEQ_DEFINES_SVH
`define PWRSEQ_DEFINES_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define CLK_KHZ 250000

// ----------------------------------------------------------------
// device bus not-ready interval, milliseconds
// ----------------------------------------------------------------
`define NOT_READY_MIN_MS 1
`define NOT_READY_TYP_MS 2
`define NOT_READY_MAX_MS 10

// ----------------------------------------------------------------
// host timing
// ----------------------------------------------------------------
`define CHIP_EN_MIN_MS 0
`define CHIP_EN_TYP_MS 10
`define PRECHARGE_MS 1
`define POLL_GAP_CYC 64
`define RESP_TIMEOUT_CYC 16

// ----------------------------------------------------------------
// command indices
// ----------------------------------------------------------------
`define CMD_IO_SEND_OP 6'h05
`define CMD_SEND_ADDR 6'h03
`define CMD_SELECT_CARD 6'h07
`define INIT_LAST_STEP 2'h3

// ----------------------------------------------------------------
// fuse store layout
// ----------------------------------------------------------------
`define FUSE_WORDS 4
`define FUSE_WIDTH 8

`endif

// ---- include/pwrseq_pkg.sv ----
// types shared by both ends of the power-up sequencer
package pwrseq_pkg;

  typedef enum logic [2:0] {
    DEV_OFF = 3'b000,
    DEV_PMU = 3'b001,
    DEV_BLOCK_ON = 3'b010,
    DEV_FUSE = 3'b011,
    DEV_PULLUP = 3'b100,
    DEV_NOT_READY = 3'b101,
    DEV_READY = 3'b110
  } dev_state_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0000,
    H_CE_WAIT = 4'b0001,
    H_PRECHARGE = 4'b0010,
    H_POLL = 4'b0011,
    H_POLL_WAIT = 4'b0100,
    H_GAP = 4'b0101,
    H_INIT_SEND = 4'b0110,
    H_INIT_WAIT = 4'b0111,
    H_DONE = 4'b1000
  } host_state_t;

endpackage : pwrseq_pkg

// ---- include/sdio_pwr_link.sv ----
// link between host controller and device: enables, command strobe and answer
`timescale 1ns/1ps
`default_nettype none

interface sdio_pwr_link;
  logic chip_en;
  logic host_iface_reset_line;
  logic cmd_valid;
  logic [5:0] cmd_index;
  logic resp_valid;
  logic resp_ready_bit;
  logic [5:0] resp_index;
  logic pullup_en;

  modport device (
    input chip_en, host_iface_reset_line, cmd_valid, cmd_index,
    output resp_valid, resp_ready_bit, resp_index, pullup_en
  );

  modport host (
    output chip_en, host_iface_reset_line, cmd_valid, cmd_index,
    input resp_valid, resp_ready_bit, resp_index, pullup_en
  );
endinterface : sdio_pwr_link

`default_nettype wire

// ---- rtl/sdio_dev_seq.sv ----
// device end: power management bring-up, fuse autoload, pull-ups and interface select
`include "pwrseq_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sdio_dev_seq
  import pwrseq_pkg::*;
#(
  parameter int unsigned CLK_KHZ = `CLK_KHZ,
  parameter int unsigned NOT_READY_CYC = `NOT_READY_TYP_MS * CLK_KHZ,
  parameter int unsigned FUSE_WORDS = `FUSE_WORDS,
  parameter int unsigned FUSE_WIDTH = `FUSE_WIDTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic supply_ok,
  input wire logic fuse_prog_en,
  input wire logic [$clog2(FUSE_WORDS)-1:0] fuse_prog_addr,
  input wire logic [FUSE_WIDTH-1:0] fuse_prog_data,
  output logic pmu_en,
  output logic sdio_block_en,
  output logic fuse_loaded,
  output logic bus_ready,
  output logic iface_selected,
  output logic [FUSE_WORDS*FUSE_WIDTH-1:0] fuse_cfg,
  sdio_pwr_link.device link
);

  localparam int unsigned AW = $clog2(FUSE_WORDS);
  // window scales with the clock rate, so a slower clock keeps the same milliseconds
  localparam int unsigned NR_MIN_CYC = `NOT_READY_MIN_MS * CLK_KHZ;
  localparam int unsigned NR_MAX_CYC = `NOT_READY_MAX_MS * CLK_KHZ;
  // an out-of-range setting is pulled back into the legal window
  localparam int unsigned NR_LEN = (NOT_READY_CYC < NR_MIN_CYC) ? NR_MIN_CYC :
                                   (NOT_READY_CYC > NR_MAX_CYC) ? NR_MAX_CYC :
                                   NOT_READY_CYC;
  localparam logic [31:0] NR_LAST = 32'(NR_LEN - 1);
  localparam logic [AW-1:0] FUSE_LAST = AW'(FUSE_WORDS - 1);

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  dev_state_t state_reg;
  dev_state_t state_next;
  logic [31:0] nr_cnt_reg;
  logic [AW-1:0] fuse_idx_reg;
  logic [FUSE_WIDTH-1:0] fuse_mem [FUSE_WORDS];
  logic [FUSE_WIDTH-1:0] fuse_cfg_reg [FUSE_WORDS];
  logic pmu_en_reg;
  logic block_en_reg;
  logic fuse_loaded_reg;
  logic pullup_reg;
  logic ready_reg;
  logic sel_reg;
  logic resp_valid_reg;
  logic resp_ready_reg;
  logic [5:0] resp_index_reg;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // losing either host-held line drops the whole function at once
  wire power_held = link.chip_en && link.host_iface_reset_line;
  wire power_up_req = supply_ok && power_held;
  wire cmd_known = (link.cmd_index == `CMD_IO_SEND_OP) ||
                   (link.cmd_index == `CMD_SEND_ADDR) ||
                   (link.cmd_index == `CMD_SELECT_CARD);
  // commands are only seen once the bus block is powered
  wire cmd_taken = link.cmd_valid && cmd_known && block_en_reg;
  // selection waits for both autoload and pull-ups
  wire sel_allowed = fuse_loaded_reg && pullup_reg;
  wire sel_hit = cmd_taken && sel_allowed && !sel_reg;
  wire nr_running = (state_reg == DEV_BLOCK_ON) || (state_reg == DEV_FUSE) ||
                    (state_reg == DEV_PULLUP) || (state_reg == DEV_NOT_READY);
  wire nr_done = (nr_cnt_reg >= NR_LAST);
  wire fuse_last = (fuse_idx_reg == FUSE_LAST);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // next-state choice; power loss wins over every step
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DEV_OFF: begin
        if (power_up_req) begin
          state_next = DEV_PMU;
        end
      end
      DEV_PMU: begin
        state_next = DEV_BLOCK_ON;
      end
      DEV_BLOCK_ON: begin
        state_next = DEV_FUSE;
      end
      DEV_FUSE: begin
        if (fuse_last) begin
          state_next = DEV_PULLUP;
        end
      end
      DEV_PULLUP: begin
        state_next = DEV_NOT_READY;
      end
      DEV_NOT_READY: begin
        if (nr_done) begin
          state_next = DEV_READY;
        end
      end
      DEV_READY: begin
        state_next = DEV_READY;
      end
      default: begin
        state_next = DEV_OFF;
      end
    endcase
    if (!power_up_req) begin
      state_next = DEV_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= DEV_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // not-ready interval counter
  // ----------------------------------------------------------------
  // starts with the bus block, so the fuse walk lies inside the interval
  always_ff @(posedge clk) begin
    if (srst || !nr_running) begin
      nr_cnt_reg <= 32'h0000_0000;
    end else if (!nr_done) begin
      nr_cnt_reg <= nr_cnt_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // enables and flags
  // ----------------------------------------------------------------
  // each flag follows the sequencer and clears on power loss
  always_ff @(posedge clk) begin
    if (srst || state_next == DEV_OFF) begin
      pmu_en_reg <= 1'b0;
      block_en_reg <= 1'b0;
      fuse_loaded_reg <= 1'b0;
      pullup_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      pmu_en_reg <= 1'b1;
      if (state_reg == DEV_PMU) begin
        block_en_reg <= 1'b1;
      end
      if (state_reg == DEV_FUSE && fuse_last) begin
        fuse_loaded_reg <= 1'b1;
      end
      if (state_reg == DEV_PULLUP && fuse_loaded_reg) begin
        pullup_reg <= 1'b1;
      end
      if (state_next == DEV_READY) begin
        ready_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // fuse store and autoload
  // ----------------------------------------------------------------
  // programming port writes the store; no reset so it keeps across power loss
  always_ff @(posedge clk) begin
    if (fuse_prog_en) begin
      fuse_mem[fuse_prog_addr] <= fuse_prog_data;
    end
  end

  // one word per cycle into the bus circuitry shadow
  always_ff @(posedge clk) begin
    if (srst || state_reg != DEV_FUSE) begin
      fuse_idx_reg <= '0;
    end else if (!fuse_last) begin
      fuse_idx_reg <= fuse_idx_reg + AW'(1);
    end
  end

  for (genvar i = 0; i < FUSE_WORDS; i++) begin : g_cfg
    always_ff @(posedge clk) begin
      if (srst) begin
        fuse_cfg_reg[i] <= '0;
      end else if (state_reg == DEV_FUSE && fuse_idx_reg == AW'(i)) begin
        fuse_cfg_reg[i] <= fuse_mem[i];
      end
    end
    assign fuse_cfg[i*FUSE_WIDTH +: FUSE_WIDTH] = fuse_cfg_reg[i];
  end

  // ----------------------------------------------------------------
  // command answer and interface select
  // ----------------------------------------------------------------
  // commands are answered during the interval, ready bit still clear
  always_ff @(posedge clk) begin
    if (srst) begin
      resp_valid_reg <= 1'b0;
      resp_ready_reg <= 1'b0;
      resp_index_reg <= 6'h00;
    end else begin
      resp_valid_reg <= cmd_taken;
      if (cmd_taken) begin
        resp_ready_reg <= ready_reg;
        resp_index_reg <= link.cmd_index;
      end
    end
  end

  // selection is sticky until power goes
  always_ff @(posedge clk) begin
    if (srst || state_next == DEV_OFF) begin
      sel_reg <= 1'b0;
    end else if (sel_hit) begin
      sel_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pmu_en = pmu_en_reg;
  assign sdio_block_en = block_en_reg;
  assign fuse_loaded = fuse_loaded_reg;
  assign bus_ready = ready_reg;
  assign iface_selected = sel_reg;
  assign link.pullup_en = pullup_reg;
  assign link.resp_valid = resp_valid_reg;
  assign link.resp_ready_bit = resp_ready_reg;
  assign link.resp_index = resp_index_reg;

endmodule : sdio_dev_seq

`default_nettype wire

// ---- rtl/sdio_host_seq.sv ----
// host end: chip enable timing, precharge, ready polling and init command order
`include "pwrseq_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sdio_host_seq
  import pwrseq_pkg::*;
#(
  parameter int unsigned CHIP_EN_CYC = `CHIP_EN_TYP_MS * `CLK_KHZ,
  parameter int unsigned PRECHARGE_CYC = `PRECHARGE_MS * `CLK_KHZ,
  parameter int unsigned POLL_GAP_CYC = `POLL_GAP_CYC,
  parameter int unsigned RESP_TIMEOUT_CYC = `RESP_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic supply_ok,
  output logic precharge,
  output logic ready_seen,
  output logic detect_done,
  sdio_pwr_link.host link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  host_state_t state_reg;
  host_state_t state_next;
  logic [31:0] cnt_reg;
  logic [1:0] step_reg;
  logic chip_en_reg;
  logic reset_line_reg;
  logic cmd_valid_reg;
  logic [5:0] cmd_index_reg;
  logic ready_seen_reg;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire ce_due = (cnt_reg >= 32'(CHIP_EN_CYC));
  wire pre_due = (cnt_reg >= 32'(PRECHARGE_CYC));
  wire gap_due = (cnt_reg >= 32'(POLL_GAP_CYC));
  wire timed_out = (cnt_reg >= 32'(RESP_TIMEOUT_CYC));
  wire step_last = (step_reg == `INIT_LAST_STEP);
  // fixed order: five, five, three, seven
  wire [5:0] step_cmd = (step_reg[1] == 1'b0) ? `CMD_IO_SEND_OP :
                        (step_reg[0] == 1'b0) ? `CMD_SEND_ADDR : `CMD_SELECT_CARD;
  wire issue = (state_reg == H_POLL) || (state_reg == H_INIT_SEND);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      H_IDLE: if (supply_ok) begin
        state_next = H_CE_WAIT;
      end
      H_CE_WAIT: if (ce_due) begin
        state_next = H_PRECHARGE;
      end
      H_PRECHARGE: if (pre_due) begin
        state_next = H_POLL;
      end
      H_POLL: state_next = H_POLL_WAIT;
      H_POLL_WAIT: begin
        // full detection only once the ready bit is seen
        if (link.resp_valid && link.resp_ready_bit) begin
          state_next = H_INIT_SEND;
        end else if (link.resp_valid || timed_out) begin
          state_next = H_GAP;
        end
      end
      H_GAP: if (gap_due) begin
        state_next = H_POLL;
      end
      H_INIT_SEND: state_next = H_INIT_WAIT;
      H_INIT_WAIT: begin
        if (link.resp_valid && step_last) begin
          state_next = H_DONE;
        end else if (link.resp_valid) begin
          state_next = H_INIT_SEND;
        end else if (timed_out) begin
          state_next = H_GAP;
        end
      end
      H_DONE: state_next = H_DONE;
      default: state_next = H_IDLE;
    endcase
    if (!supply_ok) begin
      state_next = H_IDLE;
    end
  end

  // shared counter restarts on every state change
  always_ff @(posedge clk) begin
    if (srst || state_next != state_reg) begin
      cnt_reg <= 32'h0000_0000;
    end else if (cnt_reg != 32'hffff_ffff) begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= H_IDLE;
      step_reg <= 2'h0;
      ready_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_next == H_IDLE || state_next == H_GAP) begin
        step_reg <= 2'h0;
      end else if (state_reg == H_INIT_WAIT && link.resp_valid && !step_last) begin
        step_reg <= step_reg + 2'h1;
      end
      if (state_next == H_IDLE) begin
        ready_seen_reg <= 1'b0;
      end else if (state_reg == H_POLL_WAIT && state_next == H_INIT_SEND) begin
        ready_seen_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  // enables stay high for as long as supplies are up
  always_ff @(posedge clk) begin
    if (srst || state_next == H_IDLE) begin
      chip_en_reg <= 1'b0;
      reset_line_reg <= 1'b0;
    end else if (state_reg == H_CE_WAIT && ce_due) begin
      chip_en_reg <= 1'b1;
      reset_line_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_valid_reg <= 1'b0;
      cmd_index_reg <= 6'h00;
    end else begin
      cmd_valid_reg <= issue;
      if (issue) begin
        cmd_index_reg <= (state_reg == H_POLL) ? `CMD_IO_SEND_OP : step_cmd;
      end
    end
  end

  assign link.chip_en = chip_en_reg;
  assign link.host_iface_reset_line = reset_line_reg;
  assign link.cmd_valid = cmd_valid_reg;
  assign link.cmd_index = cmd_index_reg;
  assign precharge = (state_reg == H_PRECHARGE);
  assign ready_seen = ready_seen_reg;
  assign detect_done = (state_reg == H_DONE);

endmodule : sdio_host_seq

`default_nettype wire

// ---- verif/host_iface_power_up_seq_props.sv ----
// checker for the link between host and device power-up sequencers
`include "pwrseq_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module host_iface_power_up_seq_props #(
  parameter int unsigned CLK_KHZ = `CLK_KHZ
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic chip_en,
  input wire logic host_iface_reset_line,
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_index,
  input wire logic resp_valid,
  input wire logic resp_ready_bit,
  input wire logic [5:0] resp_index,
  input wire logic pullup_en
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  // the interval starts six cycles before the pull-ups, so the floor sits six under 1 ms
  localparam int READY_MIN = int'(`NOT_READY_MIN_MS * CLK_KHZ) - 6;
  localparam int READY_MAX = int'(`NOT_READY_MAX_MS * CLK_KHZ);
  logic [31:0] up_cnt_reg;
  logic [31:0] up_cnt_next;
  wire logic known_cmd = (cmd_index == 6'h05) || (cmd_index == 6'h03) || (cmd_index == 6'h07);

  // cycles since the pull-ups came on
  assign up_cnt_next = pullup_en ? up_cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge clk) begin
    if (srst) up_cnt_reg <= 32'h0;
    else up_cnt_reg <= up_cnt_next;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_ce_up; $rose(chip_en); endsequence
  sequence s_quiet; !cmd_valid [*8]; endsequence
  sequence s_cmd3; cmd_valid && cmd_index == 6'h03; endsequence
  sequence s_cmd7; cmd_valid && cmd_index == 6'h07; endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_answer_after_cmd: assert property (cmd_valid && known_cmd && pullup_en |=>
    resp_valid && resp_index == $past(cmd_index)) else $error("command not answered");
  a_no_stray_answer: assert property (resp_valid |-> $past(cmd_valid))
    else $error("answer without command");
  a_answer_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("answer longer than one cycle");
  a_enables_paired: assert property (chip_en == host_iface_reset_line)
    else $error("reset line and chip enable differ");
  a_quiet_off: assert property (!chip_en |-> !cmd_valid)
    else $error("command while chip disabled");
  a_precharge_gap: assert property (s_ce_up |-> s_quiet)
    else $error("command during precharge");
  a_pullup_late: assert property ($rose(pullup_en) |->
    $past(chip_en, 8) && !$past(chip_en, 9)) else $error("pull-up timing wrong");
  a_ready_not_early: assert property (resp_valid && resp_ready_bit |->
    up_cnt_reg >= READY_MIN) else $error("ready bit too early");
  a_ready_not_late: assert property (resp_valid && !resp_ready_bit |->
    up_cnt_reg <= READY_MAX) else $error("ready bit too late");
  a_init_three: assert property (s_cmd3 |-> resp_index == 6'h05 && resp_ready_bit)
    else $error("address command out of order");
  a_init_seven: assert property (s_cmd7 |-> resp_index == 6'h03)
    else $error("select command out of order");
endmodule : host_iface_power_up_seq_props

`default_nettype wire

// ---- verif/host_iface_power_up_seq_test.sv ----
// self-checking testbench joining host and device power-up sequencers
`include "pwrseq_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module host_iface_power_up_seq_test
  import pwrseq_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic supply_ok = 1'b0;
  logic fuse_prog_en = 1'b0;
  logic [1:0] fuse_prog_addr = 2'h0;
  logic [7:0] fuse_prog_data = 8'h00;
  logic pmu_en, sdio_block_en, fuse_loaded, bus_ready, iface_selected;
  logic [31:0] fuse_cfg;
  logic precharge, ready_seen, detect_done;
  logic [5:0] cmd_log[$];
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int t_blk = 0;
  // a slow notional clock rate shrinks the millisecond windows so the run stays short
  localparam int unsigned TB_KHZ = 100;
  localparam int NR_MIN = `NOT_READY_MIN_MS * TB_KHZ;
  localparam int NR_MAX = `NOT_READY_MAX_MS * TB_KHZ;
  // flags a bounded wait can watch
  localparam int W_CHIP_EN = 0;
  localparam int W_RESP = 1;
  localparam int W_READY = 2;
  localparam int W_DONE = 3;

  sdio_pwr_link link();

  // free-running clock and cycle count
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (link.cmd_valid === 1'b1) cmd_log.push_back(link.cmd_index);
  end

  sdio_dev_seq #(.CLK_KHZ(TB_KHZ), .NOT_READY_CYC(`NOT_READY_TYP_MS * TB_KHZ))
    i_sdio_dev_seq (.clk(clk), .srst(srst),
    .supply_ok(supply_ok), .fuse_prog_en(fuse_prog_en), .fuse_prog_addr(fuse_prog_addr),
    .fuse_prog_data(fuse_prog_data), .pmu_en(pmu_en), .sdio_block_en(sdio_block_en),
    .fuse_loaded(fuse_loaded), .bus_ready(bus_ready), .iface_selected(iface_selected),
    .fuse_cfg(fuse_cfg), .link(link));
  // short host delays keep the run brief; the not-ready interval cannot shrink below 1 ms
  sdio_host_seq #(.CHIP_EN_CYC(10), .PRECHARGE_CYC(10)) i_sdio_host_seq (.clk(clk),
    .srst(srst), .supply_ok(supply_ok), .precharge(precharge), .ready_seen(ready_seen),
    .detect_done(detect_done), .link(link));
  host_iface_power_up_seq_props #(.CLK_KHZ(TB_KHZ)) i_props (.clk(clk), .srst(srst),
    .chip_en(link.chip_en),
    .host_iface_reset_line(link.host_iface_reset_line), .cmd_valid(link.cmd_valid),
    .cmd_index(link.cmd_index), .resp_valid(link.resp_valid),
    .resp_ready_bit(link.resp_ready_bit), .resp_index(link.resp_index),
    .pullup_en(link.pullup_en));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  // flag picked by number, so no reference to a driven net leaves the task
  function automatic logic watched(input int sel);
    logic v;
    case (sel)
      W_CHIP_EN: v = link.chip_en;
      W_RESP: v = link.resp_valid;
      W_READY: v = bus_ready;
      default: v = detect_done;
    endcase
    return v;
  endfunction : watched

  // bounded wait; a wait that runs out ends the run
  task automatic wait_until(input int sel, input int limit);
    int n;
    n = 0;
    while (watched(sel) !== 1'b1) begin
      if (n == limit) begin
        err_total++;
        $display("mismatch wait expected 1 seen 0");
        complete_run();
      end
      step(1);
      n++;
    end
  endtask : wait_until

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_power_up();
    logic [7:0] fv[4] = '{8'h3c, 8'ha5, 8'h0f, 8'hd2};
    int tp, tb, tf, tu;
    logic early_sel, pre_seen;
    tp = -1; tb = -1; tf = -1; tu = -1;
    early_sel = 1'b0; pre_seen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      fuse_prog_en = 1'b1;
      fuse_prog_addr = 2'(i);
      fuse_prog_data = fv[i];
      step(1);
    end
    fuse_prog_en = 1'b0;
    supply_ok = 1'b1;
    step(2);
    check("pmu before enable", pmu_en, 0);
    wait_until(W_CHIP_EN, 40);
    check("reset line", link.host_iface_reset_line, 1);
    for (int i = 0; i < 12; i++) begin
      step(1);
      if (pmu_en === 1'b1 && tp < 0) tp = i;
      if (sdio_block_en === 1'b1 && tb < 0) tb = i;
      if (sdio_block_en === 1'b1 && tb == i) t_blk = cyc;
      if (fuse_loaded === 1'b1 && tf < 0) tf = i;
      if (link.pullup_en === 1'b1 && tu < 0) tu = i;
      if (iface_selected !== 1'b0) early_sel = 1'b1;
      if (precharge === 1'b1) pre_seen = 1'b1;
    end
    check("pmu before block", 32'(tp < tb && tp >= 0), 1);
    // one cycle to enter the copy step, then one word a cycle
    check("fuse after block", 32'(tf - tb), 32'(`FUSE_WORDS + 1));
    check("pull-up after fuse", 32'(tu - tf), 1);
    check("fuse words", fuse_cfg, {fv[3], fv[2], fv[1], fv[0]});
    check("early select", early_sel, 0);
    check("precharge seen", pre_seen, 1);
    check("traffic before pull-up", 32'(cmd_log.size()), 0);
    wait_until(W_RESP, 40);
    check("first answer index", link.resp_index, 32'h05);
    check("first ready bit", link.resp_ready_bit, 0);
    step(1);
    check("selected", iface_selected, 1);
    check("ready seen early", ready_seen, 0);
    $display("test_power_up done");
  endtask : test_power_up

  task automatic test_ready_detect();
    int n;
    wait_until(W_READY, NR_MAX + 100);
    n = cyc - t_blk;
    check("not-ready span in range", 32'(n >= NR_MIN && n <= NR_MAX), 1);
    wait_until(W_DONE, 2000);
    check("ready seen", ready_seen, 1);
    n = cmd_log.size();
    check("init order", {cmd_log[n-4], cmd_log[n-3], cmd_log[n-2], cmd_log[n-1]},
      {6'h05, 6'h05, 6'h03, 6'h07});
    check("still selected", iface_selected, 1);
    $display("test_ready_detect done");
  endtask : test_ready_detect

  task automatic test_supply_drop();
    int n;
    n = cmd_log.size();
    supply_ok = 1'b0;
    step(2);
    check("chip enable dropped", link.chip_en, 0);
    check("reset line dropped", link.host_iface_reset_line, 0);
    check("pmu off", {pmu_en, sdio_block_en, link.pullup_en, bus_ready}, 0);
    check("select lost", iface_selected, 0);
    check("detect cleared", detect_done, 0);
    step(20);
    check("quiet after drop", 32'(cmd_log.size() - n), 0);
    $display("test_supply_drop done");
  endtask : test_supply_drop

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    step(20);
    srst = 1'b0;
    step(1);
    test_power_up();
    test_ready_detect();
    test_supply_drop();
    complete_run();
  end
endmodule : host_iface_power_up_seq_test

`default_nettype wire
